// ---- src/fcl_pkg.sv ----
// Purpose: Shared constants and types for the flash command launcher.
// Assumes: One 16-bit control register on a 32-bit peripheral bus at offset zero.
// Notes:   Command codes cover the row erase and page write operations.
package fcl_pkg;

   // ********************************
   // Register map and field layout.
   // ********************************
   localparam logic [7:0]  FCL_CTRL_OFFSET = 8'h00;
   localparam int          FCL_CMD_LSB     = 0;
   localparam int          FCL_CMD_MSB     = 6;
   localparam int          FCL_KEY_LSB     = 8;
   localparam int          FCL_KEY_MSB     = 15;
   localparam logic [6:0]  FCL_CMD_RESET   = 7'h00;
   localparam logic [7:0]  FCL_KEY_RESET   = 8'h00;
   localparam logic [7:0]  FCL_EXEC_KEY    = 8'hA5;

   // ********************************
   // Command codes.
   // ********************************
   localparam logic [6:0]  FCL_ERASE_ROW   = 7'h02;
   localparam logic [6:0]  FCL_WRITE_PAGE  = 7'h04;

   typedef enum logic [2:0] {
      FCL_IDLE = 3'b001,
      FCL_PEND = 3'b010,
      FCL_BUSY = 3'b100
   } fcl_state_t;

   typedef struct packed {
      fcl_state_t  st;
      logic [6:0]  cmd;
      logic [7:0]  key;
      logic        err;
      logic        start;
      logic [6:0]  code;
      logic [15:0] addr;
      logic [15:0] rdata;
   } fcl_regs_t;

   // Operation handed to the flash array.
   typedef struct packed {
      logic        start;
      logic        erase_row_command;
      logic        write_page;
      logic [6:0]  code;
      logic [15:0] word_addr;
   } fcl_op_t;

endpackage

// ---- src/fcl_launcher.sv ----
// Purpose: Accepts keyed commands on the peripheral bus and launches flash operations.
// Assumes: System-bus activity, array busy and done come from logic on the same clock.
// Notes:   The error flag is sticky; a clear pulse loses to a simultaneous new error.
`timescale 1ns/1ps
module fcl_launcher
   import fcl_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic              ahb_access,
   input  wire logic              nvm_busy,
   input  wire logic              op_done,
   input  wire logic [15:0]       nvm_addr,
   input  wire logic              error_clear,
   output      logic              program_error_flag,
   output      logic              nvm_ready,
   output      fcl_op_t           op
);

   // ********************************
   // State and next-state logic.
   // ********************************
   fcl_regs_t q;
   fcl_regs_t next_q;
   logic      wr;
   logic      sel_ctrl;
   logic      key_ok;

   assign sel_ctrl = (paddr == ADDR_W'(FCL_CTRL_OFFSET));
   assign wr       = psel && penable && pwrite && sel_ctrl;
   assign key_ok   = (pwdata[FCL_KEY_MSB:FCL_KEY_LSB] == FCL_EXEC_KEY);

   always_comb begin
      next_q       = q;
      next_q.start = 1'b0;
      if (error_clear) begin
         next_q.err = 1'b0;
      end
      // Capture read data in the setup phase so prdata comes from flops.
      if (psel && !penable) begin
         next_q.rdata = sel_ctrl ? {q.key, 1'b0, q.cmd} : 16'h0000;
      end
      case (q.st)
         FCL_IDLE: begin
         end
         FCL_PEND: begin
            if (!ahb_access && !nvm_busy) begin
               next_q.st    = FCL_BUSY;
               next_q.start = 1'b1;
               next_q.code  = q.cmd;
               next_q.addr  = nvm_addr;
               next_q.key   = {q.key[7:1], 1'b0};
            end
         end
         FCL_BUSY: begin
            if (op_done) begin
               next_q.st = FCL_IDLE;
            end
         end
         default: begin
            next_q.st = FCL_IDLE;
         end
      endcase
      if (wr) begin
         // Only an idle launcher takes new fields, so a refused write cannot
         // alter the code or the key readback of a command already queued or running.
         if (q.st == FCL_IDLE) begin
            // Both fields come from the one write.
            next_q.cmd = pwdata[FCL_CMD_MSB:FCL_CMD_LSB];
            next_q.key = pwdata[FCL_KEY_MSB:FCL_KEY_LSB];
         end
         if (!key_ok) begin
            next_q.err = 1'b1;
         end else if (q.st != FCL_IDLE) begin
            // An earlier command still owns the launcher.
            next_q.err = 1'b1;
         end else begin
            next_q.st = FCL_PEND;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '{st: FCL_IDLE, cmd: FCL_CMD_RESET, key: FCL_KEY_RESET, err: 1'b0,
                start: 1'b0, code: FCL_CMD_RESET, addr: 16'h0000, rdata: 16'h0000};
      end else begin
         q <= next_q;
      end
   end

   // ********************************
   // Outputs.
   // ********************************
   assign prdata                = {16'h0000, q.rdata};
   assign pready                = 1'b1;
   assign pslverr               = 1'b0;
   assign program_error_flag    = q.err;
   assign nvm_ready             = (q.st == FCL_IDLE);
   always_comb begin
      op.start             = q.start;
      op.erase_row_command = q.start && (q.code == FCL_ERASE_ROW);
      op.write_page        = q.start && (q.code == FCL_WRITE_PAGE);
      op.code              = q.code;
      op.word_addr         = q.addr;
   end

   // ********************************
   // Assertions.
   // ********************************
   a_good_key_launch: assert property (@(posedge clk) disable iff (!reset_n)
      wr && key_ok && q.st == FCL_IDLE |=> q.st == FCL_PEND && q.key[0])
      else $error("Keyed write in idle did not queue the command.");

   a_bad_key_error: assert property (@(posedge clk) disable iff (!reset_n)
      wr && !key_ok |=> program_error_flag && !($past(q.st) == FCL_IDLE && q.st != FCL_IDLE))
      else $error("Wrong key did not flag an error or queued a command.");

   a_early_cmd_error: assert property (@(posedge clk) disable iff (!reset_n)
      wr && key_ok && q.st != FCL_IDLE |=> program_error_flag && q.cmd == $past(q.cmd) &&
         ($past(q.st) == FCL_PEND || !op.start))
      else $error("Command during busy was not flagged.");

   a_ahb_priority: assert property (@(posedge clk) disable iff (!reset_n)
      q.st == FCL_PEND && (ahb_access || nvm_busy) |=> !op.start)
      else $error("Command started during system-bus or array activity.");

   a_idle_issue: assert property (@(posedge clk) disable iff (!reset_n)
      q.st == FCL_PEND && !ahb_access && !nvm_busy |=> op.start ##1 !op.start)
      else $error("Deferred command did not start once both were idle.");

   a_key_bit_clear: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(op.start) |-> !q.key[0] && $past(q.key[0]))
      else $error("Key bit 0 did not fall on issue.");

   a_word_address: assert property (@(posedge clk) disable iff (!reset_n)
      op.start |-> op.word_addr == $past(nvm_addr))
      else $error("Issued address is not the sampled word address.");

   a_field_layout: assert property (@(posedge clk) disable iff (!reset_n)
      wr && key_ok && q.st == FCL_IDLE |=> q.cmd == $past(pwdata[6:0]))
      else $error("Command field not taken from bits 6:0.");

   a_erase_decode: assert property (@(posedge clk) disable iff (!reset_n)
      op.start && op.code == 7'h02 |-> op.erase_row_command && !op.write_page)
      else $error("Erase row not decoded.");

   a_write_decode: assert property (@(posedge clk) disable iff (!reset_n)
      op.start && op.code == 7'h04 |-> op.write_page && !op.erase_row_command)
      else $error("Write page not decoded.");

   a_ready_low: assert property (@(posedge clk) disable iff (!reset_n)
      op.start && !op_done |=> !nvm_ready)
      else $error("Ready high while a command runs.");

   a_start_from_pend: assert property (@(posedge clk) disable iff (!reset_n)
      op.start |-> $past(q.st) == FCL_PEND)
      else $error("Command started without a keyed write.");

   a_code_from_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      op.start |-> op.code == $past(q.cmd))
      else $error("Issued code differs from the written command.");

   a_pend_keeps_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      q.st != FCL_IDLE && wr && !key_ok |=> q.cmd == $past(q.cmd))
      else $error("Wrong key changed a queued command.");

   a_error_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      program_error_flag && !error_clear |=> program_error_flag)
      else $error("Error flag fell without a clear.");

   a_set_beats_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wr && (!key_ok || q.st != FCL_IDLE) && error_clear |=> program_error_flag)
      else $error("Clear won over a new error.");

   a_addr_holds: assert property (@(posedge clk) disable iff (!reset_n)
      !op.start |-> $stable(op.word_addr))
      else $error("Word address changed without an issue.");

   a_key_layout: assert property (@(posedge clk) disable iff (!reset_n)
      wr && key_ok && q.st == FCL_IDLE |=> q.key == $past(pwdata[15:8]))
      else $error("Key field not taken from bits 15:8.");

   a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
      psel && !penable && !sel_ctrl |=> prdata == 32'h00000000)
      else $error("Unmapped read returned nonzero data.");

   a_decode_only_start: assert property (@(posedge clk) disable iff (!reset_n)
      op.erase_row_command || op.write_page |-> op.start)
      else $error("Operation decode without a start.");

   a_pend_not_ready: assert property (@(posedge clk) disable iff (!reset_n)
      q.st == FCL_PEND |-> !nvm_ready)
      else $error("Ready high while a command is queued.");

   a_done_ready: assert property (@(posedge clk) disable iff (!reset_n)
      q.st == FCL_BUSY && op_done |=> nvm_ready)
      else $error("Ready did not return after completion.");

endmodule

// ---- verif/fcl_flash_model.sv ----
// Purpose: Behavioural flash array answering launched operations.
// Assumes: Each operation keeps the array busy for a fixed time.
// Notes:   Busy rises on the launch pulse and done pulses at the end.
`timescale 1ns/1ps
module fcl_flash_model
   import fcl_pkg::*;
#(
   parameter int DLY = 6
) (
   input  wire logic    clk,
   input  wire logic    reset_n,
   input  wire fcl_op_t op,
   output      logic    nvm_busy,
   output      logic    op_done
);
   int cnt;
   always_ff @(posedge clk) begin
      op_done <= 1'b0;
      if (!reset_n) begin
         cnt <= 0;
         nvm_busy <= 1'b0;
      end else if (op.start) begin
         cnt <= DLY;
         nvm_busy <= 1'b1;
      end else if (cnt == 1) begin
         cnt <= 0;
         nvm_busy <= 1'b0;
         op_done <= 1'b1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ---- verif/tb_flash_command_launcher.sv ----
// Purpose: Self-checking bench for the flash command launcher.
// Assumes: The flash model answers each launch after a fixed busy time.
// Notes:   System-bus activity is driven here to force a deferred launch.
`timescale 1ns/1ps
module tb_flash_command_launcher;
   import fcl_pkg::*;
   logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, ahb_access = 0, nvm_busy, op_done;
   logic [15:0] nvm_addr = 16'h0000;
   logic        error_clear = 0, program_error_flag, nvm_ready;
   fcl_op_t     op;
   int          num_errors = 0, n_checks = 0, cycles = 0;
   logic [31:0] rd;
   always #5 clk = ~clk;
   fcl_launcher #(.ADDR_W(8)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ahb_access(ahb_access), .nvm_busy(nvm_busy),
      .op_done(op_done), .nvm_addr(nvm_addr), .error_clear(error_clear),
      .program_error_flag(program_error_flag), .nvm_ready(nvm_ready), .op(op));
   fcl_flash_model FLASH (.clk(clk), .reset_n(reset_n), .op(op), .nvm_busy(nvm_busy),
      .op_done(op_done));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Setup edge, then the access edge where pready is sampled and read data is taken.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      chk({pready, pslverr}, 2'b10);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_start();
      @(negedge clk);
      for (int i = 0; i < 20 && op.start !== 1'b1; i++) @(negedge clk);
      chk(op.start, 1'b1);
   endtask
   task wait_ready();
      @(negedge clk);
      for (int i = 0; i < 20 && nvm_ready !== 1'b1; i++) @(negedge clk);
      chk(nvm_ready, 1'b1);
   endtask
   task clear_err();
      @(posedge clk);
      error_clear <= 1'b1;
      @(posedge clk);
      error_clear <= 1'b0;
      @(negedge clk);
      chk(program_error_flag, 1'b0);
   endtask
   task t_reset();
      reset_n <= 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk({nvm_ready, program_error_flag, op.start}, 3'b100);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
   endtask
   task t_erase();
      @(posedge clk);
      nvm_addr   <= 16'h1234;
      ahb_access <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000A502);
      repeat (3) @(negedge clk);
      chk({nvm_ready, op.start}, 2'b00);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000A502);
      apb(1'b1, 8'h00, 32'h00005A03);
      @(negedge clk);
      chk(program_error_flag, 1'b1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000A502);
      clear_err();
      @(posedge clk);
      ahb_access <= 1'b0;
      wait_start();
      chk({op.erase_row_command, op.write_page, op.code}, {2'b10, 7'h02});
      chk(op.word_addr, 16'h1234);
      wait_ready();
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000A402);
   endtask
   task t_busy();
      @(posedge clk);
      nvm_addr <= 16'h0040;
      @(negedge clk);
      chk(nvm_ready, 1'b1);
      apb(1'b1, 8'h00, 32'h0000A504);
      wait_start();
      chk({op.erase_row_command, op.write_page, op.code}, {2'b01, 7'h04});
      chk(op.word_addr, 16'h0040);
      apb(1'b1, 8'h00, 32'h0000A502);
      @(negedge clk);
      chk({program_error_flag, nvm_ready, op.start}, 3'b100);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000A404);
      wait_ready();
      clear_err();
   endtask
   task t_wrong();
      @(posedge clk);
      error_clear <= 1'b1;
      apb(1'b1, 8'h00, 32'h00005A04);
      error_clear <= 1'b0;
      @(negedge clk);
      chk({program_error_flag, nvm_ready, op.start}, 3'b110);
      repeat (3) @(negedge clk);
      chk({nvm_ready, op.start}, 2'b10);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h00005A04);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      t_reset();
      t_erase();
      t_busy();
      t_wrong();
      t_reset();
      stop_test();
   end
endmodule
